// >>> logic/act_clock_tree.sv
`timescale 1ns/1ps
`default_nettype none
module act_clock_tree
    import act_pkg::*;
(
    input  wire logic          mclk,
    input  wire logic          rst_b,
    input  wire logic          master_clock_in_one,
    input  wire logic          master_clock_in_two,
    input  wire logic          bit_clock_one_in,
    input  wire logic          bit_clock_two_in,
    input  wire logic          pll_out_in,
    input  wire logic          pll_locked,
    input  wire logic [1:0]    pll_ref_sel,
    input  wire logic          sys_sel_zone_two,
    input  wire logic          zone_three_sel_two,
    input  wire act_zone_cfg_t zone_one_cfg,
    input  wire act_zone_cfg_t zone_two_cfg,
    input  wire act_zone_cfg_t zone_three_cfg,
    input  wire logic          dsp_in_use,
    input  wire logic          rate_converter_one_en,
    input  wire logic          rate_converter_two_en,
    input  wire logic          direct_path_en,
    output var  logic          pll_ref_clock,
    output var  logic          system_clock_tick,
    output var  logic          system_clock_on,
    output var  logic          rate_converter_clock,
    output var  logic          src_cfg_error,
    output var  act_port_clk_t port_one_clk,
    output var  act_port_clk_t port_two_clk,
    output var  act_port_clk_t port_three_clk,
    output var  logic          port_one_clk_oe,
    output var  logic          port_two_clk_oe,
    output var  logic          osc_tick
);
    logic m1;
    logic m1_r;
    logic m2;
    logic m2_r;
    logic b1;
    logic b2;
    logic pl_r;
    logic sel_last_q;
    logic z1_tick;
    logic z2_tick;
    logic z3_tick;
    logic src_use;
    logic sys_src_q;
    logic sys_src_d;
    logic pll_ref_d;
    logic [7:0] hold_q;
    logic [$clog2(OSC_DIV)-1:0] osc_q;
    act_sw_t sw_q;

    act_sync3 u_m1 (.mclk(mclk), .rst_b(rst_b), .din(master_clock_in_one), .dout(m1), .rise(m1_r));
    act_sync3 u_m2 (.mclk(mclk), .rst_b(rst_b), .din(master_clock_in_two), .dout(m2), .rise(m2_r));
    act_sync3 u_b1 (.mclk(mclk), .rst_b(rst_b), .din(bit_clock_one_in), .dout(b1), .rise());
    act_sync3 u_b2 (.mclk(mclk), .rst_b(rst_b), .din(bit_clock_two_in), .dout(b2), .rise());
    act_sync3 u_pl (.mclk(mclk), .rst_b(rst_b), .din(pll_out_in), .dout(), .rise(pl_r));

    function automatic logic zone_tick(input act_zone_cfg_t c, input logic r1, input logic r2, input logic rp);
        zone_tick = c.zone_pll ? rp : (c.zone_master_clock_in_two ? r2 : r1);
    endfunction

    assign z1_tick = zone_tick(zone_one_cfg, m1_r, m2_r, pl_r);
    assign z2_tick = zone_tick(zone_two_cfg, m1_r, m2_r, pl_r);
    assign z3_tick = zone_three_sel_two ? z2_tick : z1_tick;
    assign src_use = rate_converter_one_en | rate_converter_two_en;

    // PLL reference mux, bit clocks only usable from slave ports
    always_comb begin
        case (pll_ref_sel)
            PREF_MASTER_CLOCK_IN_ONE: pll_ref_d = m1;
            PREF_MASTER_CLOCK_IN_TWO: pll_ref_d = m2;
            PREF_BIT_CLOCK_ONE: pll_ref_d = b1 & ~zone_one_cfg.master;
            PREF_BIT_CLOCK_TWO: pll_ref_d = b2 & ~zone_two_cfg.master;
            default:    pll_ref_d = 1'b0;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pll_ref_clock <= 1'b0;
        end else begin
            pll_ref_clock <= pll_ref_d;
        end
    end

    assign sys_src_d = sys_sel_zone_two;

    // Glitch-free switch: gate, wait, change mux, wait, reopen
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sw_q       <= ACT_SW_GATE;
            sys_src_q  <= 1'b0;
            sel_last_q <= 1'b0;
            hold_q     <= '0;
        end else begin
            sel_last_q <= sys_src_d;
            case (sw_q)
                ACT_SW_RUN: begin
                    if (sys_src_d != sys_src_q) begin
                        sw_q   <= ACT_SW_GATE;
                        hold_q <= '0;
                    end
                end
                ACT_SW_GATE: begin
                    if (hold_q >= 8'(SW_HOLD_CYC)) begin
                        sw_q      <= ACT_SW_MUX;
                        sys_src_q <= sys_src_d;
                        hold_q    <= '0;
                    end else begin
                        hold_q <= hold_q + 8'h01;
                    end
                end
                ACT_SW_MUX: begin
                    if (hold_q >= 8'(SW_HOLD_CYC)) begin
                        sw_q <= ACT_SW_OPEN;
                    end else begin
                        hold_q <= hold_q + 8'h01;
                    end
                end
                ACT_SW_OPEN: begin
                    sw_q <= ACT_SW_RUN;
                end
                default: begin
                    sw_q <= ACT_SW_GATE;
                end
            endcase
            // Request moved mid-switch: start the quiet time again
            if ((sys_src_d != sel_last_q) && (sw_q != ACT_SW_RUN)) begin
                sw_q   <= ACT_SW_GATE;
                hold_q <= '0;
            end
        end
    end

    // System clock enabled only when something needs it
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            system_clock_on      <= 1'b0;
            system_clock_tick    <= 1'b0;
            rate_converter_clock <= 1'b0;
            src_cfg_error        <= 1'b0;
        end else begin
            system_clock_on   <= (sw_q == ACT_SW_RUN) & (dsp_in_use | src_use);
            system_clock_tick <= (sw_q == ACT_SW_RUN) & (sys_src_d == sys_src_q) & (dsp_in_use | src_use)
                               & (sys_src_q ? z2_tick : z1_tick);
            src_cfg_error     <= src_use & ~((sys_src_d ? zone_two_cfg.zone_pll : zone_one_cfg.zone_pll)
                               & pll_locked);
            rate_converter_clock <= (sw_q == ACT_SW_RUN) & src_use & pll_locked & pl_r;
        end
    end

    act_port_div u_p1 (.mclk(mclk), .rst_b(rst_b), .ref_tick(z1_tick), .cfg(zone_one_cfg),
                       .run(1'b1), .clk_out(port_one_clk));
    act_port_div u_p2 (.mclk(mclk), .rst_b(rst_b), .ref_tick(z2_tick), .cfg(zone_two_cfg),
                       .run(1'b1), .clk_out(port_two_clk));
    act_port_div u_p3 (.mclk(mclk), .rst_b(rst_b), .ref_tick(z3_tick), .cfg(zone_three_cfg),
                       .run(zone_three_cfg.master), .clk_out(port_three_clk));

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            port_one_clk_oe <= 1'b0;
            port_two_clk_oe <= 1'b0;
        end else begin
            port_one_clk_oe <= zone_one_cfg.master;
            port_two_clk_oe <= zone_two_cfg.master;
        end
    end

    // Internal oscillator stand-in for direct path
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            osc_q    <= '0;
            osc_tick <= 1'b0;
        end else begin
            osc_q    <= osc_q + 1'b1;
            osc_tick <= direct_path_en & (osc_q == '1);
        end
    end
endmodule
`default_nettype wire

// >>> logic/act_pkg.sv
`default_nettype none
package act_pkg;
    localparam int unsigned CLK_HZ       = 50_000_000;
    localparam int unsigned FS_RATIO     = 512;
    localparam int unsigned SYS_HZ_48K   = 24_576_000;
    localparam int unsigned SYS_HZ_44K   = 22_579_200;
    localparam int unsigned PLL_MIN_HZ   = 128_000;
    localparam int unsigned PLL_MAX_HZ   = 24_000_000;
    localparam int unsigned NF_SCALE     = 5;
    localparam int unsigned SW_HOLD_NS   = 100;
    localparam int unsigned SW_HOLD_CYC  = (SW_HOLD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned OSC_DIV      = 16;
    localparam int unsigned BCLK_DIV_W   = 8;
    localparam int unsigned FRM_DIV_W    = 8;

    localparam logic [1:0] PREF_MASTER_CLOCK_IN_ONE = 2'h0;
    localparam logic [1:0] PREF_MASTER_CLOCK_IN_TWO = 2'h1;
    localparam logic [1:0] PREF_BIT_CLOCK_ONE = 2'h2;
    localparam logic [1:0] PREF_BIT_CLOCK_TWO = 2'h3;

    typedef enum logic [3:0] {
        ACT_SW_RUN   = 4'b0001,
        ACT_SW_GATE  = 4'b0010,
        ACT_SW_MUX   = 4'b0100,
        ACT_SW_OPEN  = 4'b1000
    } act_sw_t;

    typedef struct packed {
        logic       zone_pll;
        logic       zone_master_clock_in_two;
        logic       master;
        logic [7:0] bclk_div;
        logic [7:0] frame_bits;
    } act_zone_cfg_t;

    typedef struct packed {
        logic bit_clock;
        logic frame_sync;
    } act_port_clk_t;
endpackage
`default_nettype wire

// >>> logic/act_sync3.sv
`timescale 1ns/1ps
`default_nettype none
module act_sync3
    import act_pkg::*;
(
    input  wire logic mclk,
    input  wire logic rst_b,
    input  wire logic din,
    output var  logic dout,
    output var  logic rise
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            dout <= 1'b0;
            rise <= 1'b0;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                dout <= s3_q;
                rise <= s3_q & ~dout;
            end else begin
                rise <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// >>> logic/act_port_div.sv
`timescale 1ns/1ps
`default_nettype none
module act_port_div
    import act_pkg::*;
(
    input  wire logic          mclk,
    input  wire logic          rst_b,
    input  wire logic          ref_tick,
    input  wire act_zone_cfg_t cfg,
    input  wire logic          run,
    output var  act_port_clk_t clk_out
);
    logic [BCLK_DIV_W-1:0] bdiv_q;
    logic [FRM_DIV_W-1:0]  fcnt_q;

    // Bit clock toggles every bclk_div+1 ticks; frame sync every frame_bits+1 bits
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            bdiv_q  <= '0;
            fcnt_q  <= '0;
            clk_out <= '0;
        end else if (!run || !cfg.master) begin
            bdiv_q  <= '0;
            fcnt_q  <= '0;
            clk_out <= '0;
        end else if (ref_tick) begin
            if (bdiv_q >= cfg.bclk_div) begin
                bdiv_q <= '0;
                clk_out.bit_clock <= ~clk_out.bit_clock;
                if (clk_out.bit_clock) begin
                    if (fcnt_q >= cfg.frame_bits) begin
                        fcnt_q <= '0;
                        clk_out.frame_sync <= ~clk_out.frame_sync;
                    end else begin
                        fcnt_q <= fcnt_q + 1'b1;
                    end
                end
            end else begin
                bdiv_q <= bdiv_q + 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// >>> dv/act_clock_tree_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module act_clock_tree_monitor
    import act_pkg::*;
(
    input wire logic          mclk,
    input wire logic          rst_b,
    input wire logic [1:0]    pll_ref_sel,
    input wire logic          sys_sel_zone_two,
    input wire act_zone_cfg_t zone_one_cfg,
    input wire act_zone_cfg_t zone_two_cfg,
    input wire logic          dsp_in_use,
    input wire logic          rate_converter_one_en,
    input wire logic          rate_converter_two_en,
    input wire logic          pll_locked,
    input wire logic          direct_path_en,
    input wire logic          pll_ref_clock,
    input wire logic          system_clock_tick,
    input wire logic          rate_converter_clock,
    input wire logic          src_cfg_error,
    input wire logic          port_one_clk_oe,
    input wire logic          osc_tick
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    logic rc_en;
    logic use_any;
    logic src_bad;
    assign rc_en   = rate_converter_one_en | rate_converter_two_en;
    assign use_any = dsp_in_use | rc_en;
    assign src_bad = rc_en & ~((sys_sel_zone_two ? zone_two_cfg.zone_pll : zone_one_cfg.zone_pll) & pll_locked);
    property p_oe_one; $past(rst_b) |-> port_one_clk_oe == $past(zone_one_cfg.master); endproperty
    a_oe_one: assert property (p_oe_one) else $error("port one enable wrong");
    property p_src_err; $past(rst_b) |-> src_cfg_error == $past(src_bad); endproperty
    a_src_err: assert property (p_src_err) else $error("converter source flag wrong");
    property p_sw_gate; $past(rst_b) && $changed(sys_sel_zone_two) |-> ##2 !system_clock_tick [*5]; endproperty
    a_sw_gate: assert property (p_sw_gate) else $error("tick during source switch");
    property p_idle; system_clock_tick |-> $past(use_any) || $past(use_any, 2) || $past(use_any, 3); endproperty
    a_idle: assert property (p_idle) else $error("tick with nothing in use");
    property p_rc; rate_converter_clock |-> $past(rc_en) || $past(rc_en, 2) || $past(rc_en, 3); endproperty
    a_rc: assert property (p_rc) else $error("converter clock while unused");
    property p_osc_gap; osc_tick |=> !osc_tick [*8]; endproperty
    a_osc_gap: assert property (p_osc_gap) else $error("oscillator ticks too close");
    property p_osc_en; osc_tick |-> $past(direct_path_en) || $past(direct_path_en, 2); endproperty
    a_osc_en: assert property (p_osc_en) else $error("oscillator tick outside direct path");
    property p_ref_refused;
        (pll_ref_sel == PREF_BIT_CLOCK_ONE && zone_one_cfg.master) [*8] |-> $stable(pll_ref_clock);
    endproperty
    a_ref_refused: assert property (p_ref_refused) else $error("master bit clock used as reference");
endmodule
bind act_clock_tree act_clock_tree_monitor u_mon (.*);
`default_nettype wire

// >>> dv/act_clock_src_model.sv
`timescale 1ns/1ps
`default_nettype none
module act_clock_src_model #(
    parameter int H_M1 = 60,
    parameter int H_M2 = 90,
    parameter int H_PL = 70,
    parameter int H_B1 = 140,
    parameter int H_B2 = 110
) (
    input  wire logic port_one_clk_oe,
    input  wire logic port_two_clk_oe,
    output var  logic master_clock_in_one,
    output var  logic master_clock_in_two,
    output var  logic host_bit_one,
    output var  logic host_bit_two,
    output var  logic pll_out_in,
    output var  logic pll_locked
);
    initial {master_clock_in_one, master_clock_in_two, host_bit_one, host_bit_two, pll_out_in, pll_locked} = '0;
    initial #2000 pll_locked = 1'b1;
    // Master clocks run free from time zero
    always #(H_M1) master_clock_in_one = ~master_clock_in_one;
    always #(H_M2) master_clock_in_two = ~master_clock_in_two;
    // Host bit clock only while the port is slave
    always #(H_B1) host_bit_one = !port_one_clk_oe && !host_bit_one;
    always #(H_B2) host_bit_two = !port_two_clk_oe && !host_bit_two;
    always #(H_PL) pll_out_in = pll_locked && !pll_out_in;
endmodule
`default_nettype wire

// >>> dv/act_clock_tree_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module act_clock_tree_tb_top;
    import act_pkg::*;
    localparam int W = 600;
    localparam int HS [5] = '{60, 90, 70, 140, 110};
    logic          mclk, rst_b, master_clock_in_one, master_clock_in_two, pll_out_in, pll_locked;
    logic          bit_clock_one_in, bit_clock_two_in, host_bit_one, host_bit_two, direct_path_en;
    logic          sys_sel_zone_two, zone_three_sel_two, dsp_in_use, rate_converter_one_en;
    logic          rate_converter_two_en, pll_ref_clock, system_clock_tick, system_clock_on;
    logic          rate_converter_clock, src_cfg_error, port_one_clk_oe, port_two_clk_oe, osc_tick;
    logic [1:0]    pll_ref_sel;
    logic [6:0]    ev, prev;
    act_zone_cfg_t zone_one_cfg, zone_two_cfg, zone_three_cfg;
    act_port_clk_t port_one_clk, port_two_clk, port_three_clk;
    int            cnt [7];
    int            failures = 0, n_tests = 0, d, f;
    // Pin level from whichever side drives it
    assign bit_clock_one_in = port_one_clk_oe ? port_one_clk.bit_clock : host_bit_one;
    assign bit_clock_two_in = port_two_clk_oe ? port_two_clk.bit_clock : host_bit_two;
    assign ev = {system_clock_tick, rate_converter_clock, pll_ref_clock, port_one_clk,
                 port_three_clk.bit_clock, osc_tick};
    act_clock_tree u_dut (.*);
    act_clock_src_model #(HS[0], HS[1], HS[2], HS[3], HS[4]) u_src (.*);
    always #10 mclk = ~mclk;
    always @(posedge mclk) begin
        for (int i = 0; i < 7; i++) if (ev[i] && !prev[i]) cnt[i]++;
        prev <= ev;
    end
    function automatic int edges(input int i);
        return W * 20 / (2 * HS[i]);
    endfunction
    task automatic chk_lvl(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_cnt(input int got, input int exp);
        n_tests++;
        if (got < exp - 2 || got > exp + 2) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic run(input int n);
        cnt = '{default: 0};
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic meas;
        run(60);
        run(W);
    endtask
    task automatic finish_test;
        $display("tests=%0d failures=%0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        #1_000_000;
        failures++;
        finish_test();
    end
    initial begin
        void'($urandom(21719));
        {mclk, rst_b, sys_sel_zone_two, zone_three_sel_two, dsp_in_use, direct_path_en} = '0;
        {rate_converter_one_en, rate_converter_two_en, pll_ref_sel} = '0;
        {zone_one_cfg, zone_two_cfg, zone_three_cfg} = '0;
        repeat (3) @(posedge mclk);
        #1;
        chk_lvl({system_clock_tick, system_clock_on, rate_converter_clock, src_cfg_error, osc_tick, 3'b0},
                8'h00);
        rst_b = 1'b1;
        run(100);
        chk_lvl({system_clock_on, port_one_clk, port_two_clk, src_cfg_error, osc_tick, port_one_clk_oe},
                8'h00);
        chk_cnt(cnt[6], 0);
        dsp_in_use = 1'b1;
        for (int k = 0; k < 6; k++) begin
            zone_one_cfg = '{k % 3 == 2, k % 3 == 1, 1'b0, 8'h00, 8'h00};
            zone_two_cfg = zone_one_cfg;
            sys_sel_zone_two = k > 2;
            meas;
            chk_cnt(cnt[6], edges(k % 3));
            chk_lvl(system_clock_on, 8'h01);
        end
        repeat (30) begin
            sys_sel_zone_two = ~sys_sel_zone_two;
            repeat ($urandom_range(20, 2)) @(posedge mclk);
            #1;
        end
        zone_one_cfg.zone_pll = 1'b0;
        meas;
        chk_cnt(cnt[6], edges(sys_sel_zone_two ? 2 : 0));
        for (int k = 0; k < 4; k++) begin
            {rate_converter_two_en, rate_converter_one_en} = 2'(1 << k[0]);
            sys_sel_zone_two = k < 2;
            meas;
            chk_lvl(src_cfg_error, 8'(k >= 2));
            if (k < 2) chk_cnt(cnt[5], edges(2));
        end
        {rate_converter_one_en, rate_converter_two_en} = '0;
        for (int s = 0; s < 4; s++) begin
            pll_ref_sel = 2'(s);
            meas;
            chk_cnt(cnt[4], edges(s < 2 ? s : s + 1));
        end
        for (int k = 0; k < 3; k++) begin
            d = k == 0 ? 0 : $urandom_range(3, 0);
            f = k == 0 ? 1 : $urandom_range(7, 1);
            zone_one_cfg = '{1'b0, 1'b0, 1'b1, 8'(d), 8'(f)};
            zone_two_cfg = '{1'b0, 1'b1, 1'b0, 8'h00, 8'h00};
            zone_three_cfg = '{1'b0, 1'b1, 1'b1, 8'(d), 8'(f)};
            {sys_sel_zone_two, zone_three_sel_two, pll_ref_sel} = {2'b01, PREF_BIT_CLOCK_ONE};
            meas;
            chk_lvl({port_one_clk_oe, port_two_clk_oe}, 8'h02);
            chk_cnt(cnt[3], edges(0) / (2 * (d + 1)));
            chk_cnt(cnt[2], edges(0) / (4 * (d + 1) * (f + 1)));
            chk_cnt(cnt[1], edges(1) / (2 * (d + 1)));
        end
        dsp_in_use = 1'b0;
        for (int k = 1; k >= 0; k--) begin
            direct_path_en = k[0];
            meas;
            chk_cnt(cnt[0], k * W / OSC_DIV);
        end
        finish_test();
    end
endmodule
`default_nettype wire
